// ---- cmpc_defines.svh ----
// Purpose: Constants for the comparator control and status block
// Assumes: 8-bit special-function register space
// Notes:   Offsets, bit positions and reset values
`ifndef CMPC_DEFINES_SVH
`define CMPC_DEFINES_SVH
`define CMPC_CTRL_ADDR      8'h9b
`define CMPC_MODE_ADDR      8'h9d
`define CMPC_CTRL_RESET     8'h00
`define CMPC_MODE_RESET     8'h02
`define CMPC_MODE_MASK      8'h33
`define CMPC_BIT_EN         7
`define CMPC_BIT_OUT        6
`define CMPC_BIT_RISE       5
`define CMPC_BIT_FALL       4
`define CMPC_HYP_HI         3
`define CMPC_HYP_LO         2
`define CMPC_HYN_HI         1
`define CMPC_HYN_LO         0
`define CMPC_BIT_RIE        5
`define CMPC_BIT_FIE        4
`define CMPC_MD_HI          1
`define CMPC_MD_LO          0
`endif

// ---- cmpc_pkg.sv ----
// Purpose: Types for the comparator control and status block
// Assumes: Constants come from cmpc_defines.svh
// Notes:   Hysteresis settings and response modes
package cmpc_pkg;
    typedef enum logic [1:0] {
        CMPC_HYST_OFF = 2'h0,
        CMPC_HYST_5MV = 2'h1,
        CMPC_HYST_10MV = 2'h2,
        CMPC_HYST_20MV = 2'h3
    } cmpc_hyst_t;
    typedef logic [1:0] cmpc_mode_t;
endpackage

// ---- cmpc_top.sv ----
// Purpose: Control and status wrapper around an analogue comparator
// Assumes: Byte register port at special-function addresses, single clock
// Notes:   Analogue result arrives asynchronously and is synchronised
`timescale 1ns/100ps
`include "cmpc_defines.svh"

// Notes on behaviour
// - Enable bit 7 turns the comparator on when one, off when zero.
// - While disabled, routed output is low and comparator supply is off.
// - Routed output selectable synchronous or asynchronous; asynchronous path needs no clock.
// - Read-only bit 6 shows synchronised comparator output while enabled; reads zero while disabled.
// - Each rising output transition sets rise flag at bit 5.
// - Each falling output transition sets fall flag at bit 4.
// - Edge flags stay set until software writes zero; hardware never clears.
// - Interrupt can be requested on rising and falling transitions.
// - Rise interrupt enable gates the rise flag onto the interrupt.
// - Fall interrupt enable gates the fall flag onto the interrupt.
// - Bits 3:2 choose positive hysteresis: off, 5, 10, 20 mV.
// - Bits 1:0 choose negative hysteresis: off, 5, 10, 20 mV.
// - Separate mode register selects response time; slower uses less current.
// - Control register at 0x9B, on every page, resets to zero.
module cmpc_top (
    input  wire logic                  clk_i,
    input  wire logic                  rst_b_i,
    input  wire logic [7:0]            sfr_addr_i,
    input  wire logic                  sfr_wr_i,
    input  wire logic [7:0]            sfr_wdata_i,
    output logic      [7:0]            sfr_rdata_o,
    input  wire logic                  cmp_raw_i,
    input  wire logic                  route_async_i,
    output logic                       cmp_pin_sync_o,
    output logic                       cmp_pin_async_o,
    output logic                       cmp_power_o,
    output cmpc_pkg::cmpc_hyst_t       cmp_pos_hysteresis_o,
    output cmpc_pkg::cmpc_hyst_t       cmp_neg_hysteresis_o,
    output cmpc_pkg::cmpc_mode_t       cmp_response_mode_o,
    output logic                       cmp_rise_irq_o,
    output logic                       cmp_fall_irq_o,
    output logic                       cmp_irq_o
);
    import cmpc_pkg::*;

    // Address decode shared by the write strobes and the read mux
    function automatic logic cmpc_addr_hit(input logic [7:0] addr, input logic [7:0] target);
        return addr == target;
    endfunction

    // Flag update: a hardware set wins, a written zero clears, a written one holds
    function automatic logic cmpc_flag_next(
        input logic evt,
        input logic wr,
        input logic wbit,
        input logic cur
    );
        return evt | (wr ? (wbit & cur) : cur);
    endfunction

    logic [7:0] cmp_control_reg;
    logic [7:0] cmp_response_mode_reg;
    logic [7:0] sfr_rdata_reg;
    logic       sync1_reg;
    logic       sync2_reg;
    logic       prev_reg;
    logic       pin_sync_reg;
    logic       rise_irq_reg;
    logic       fall_irq_reg;
    logic       irq_reg;

    // Register selection
    wire logic       ctrl_hit            = cmpc_addr_hit(sfr_addr_i, `CMPC_CTRL_ADDR);
    wire logic       mode_hit            = cmpc_addr_hit(sfr_addr_i, `CMPC_MODE_ADDR);
    wire logic       ctrl_wr             = sfr_wr_i & ctrl_hit;
    wire logic       mode_wr             = sfr_wr_i & mode_hit;

    // Control register fields
    wire logic       cmp_enable          = cmp_control_reg[`CMPC_BIT_EN];
    wire logic       cmp_rise_flag       = cmp_control_reg[`CMPC_BIT_RISE];
    wire logic       cmp_fall_flag       = cmp_control_reg[`CMPC_BIT_FALL];
    wire logic [3:0] cmp_hyst_bits       = cmp_control_reg[`CMPC_HYP_HI:`CMPC_HYN_LO];
    wire logic [1:0] cmp_pos_hyst_bits   = cmp_control_reg[`CMPC_HYP_HI:`CMPC_HYP_LO];
    wire logic [1:0] cmp_neg_hyst_bits   = cmp_control_reg[`CMPC_HYN_HI:`CMPC_HYN_LO];

    // Mode register fields
    wire logic       cmp_rise_irq_enable = cmp_response_mode_reg[`CMPC_BIT_RIE];
    wire logic       cmp_fall_irq_enable = cmp_response_mode_reg[`CMPC_BIT_FIE];
    wire logic [1:0] response_mode_bits  = cmp_response_mode_reg[`CMPC_MD_HI:`CMPC_MD_LO];
    wire logic [7:0] mode_rdata          = cmp_response_mode_reg & `CMPC_MODE_MASK;

    // Write data fields
    wire logic       wr_enable_bit       = sfr_wdata_i[`CMPC_BIT_EN];
    wire logic       wr_rise_bit         = sfr_wdata_i[`CMPC_BIT_RISE];
    wire logic       wr_fall_bit         = sfr_wdata_i[`CMPC_BIT_FALL];
    wire logic [3:0] wr_hyst_bits        = sfr_wdata_i[`CMPC_HYP_HI:`CMPC_HYN_LO];

    // Comparator result and edge detection
    wire logic       cmp_output_state    = cmp_enable & sync2_reg;
    wire logic       rise_evt            = cmp_output_state & ~prev_reg;
    wire logic       fall_evt            = ~cmp_output_state & prev_reg;

    // Next value of the control register
    wire logic       enable_next         = ctrl_wr ? wr_enable_bit : cmp_enable;
    wire logic       rise_next           = cmpc_flag_next(rise_evt, ctrl_wr, wr_rise_bit,
                                                          cmp_rise_flag);
    wire logic       fall_next           = cmpc_flag_next(fall_evt, ctrl_wr, wr_fall_bit,
                                                          cmp_fall_flag);
    wire logic [3:0] hyst_next           = ctrl_wr ? wr_hyst_bits : cmp_hyst_bits;
    wire logic [7:0] ctrl_next           = {
        enable_next,
        cmp_output_state,
        rise_next,
        fall_next,
        hyst_next
    };

    // Read data for the address of this edge
    wire logic [7:0] rdata_next          = ctrl_hit ? ctrl_next :
                                           mode_hit ? mode_rdata :
                                           8'h00;

    // Pin and interrupt next values
    wire logic       pin_sync_next       = cmp_output_state & ~route_async_i;
    wire logic       rise_irq_next       = cmp_rise_flag & cmp_rise_irq_enable;
    wire logic       fall_irq_next       = cmp_fall_flag & cmp_fall_irq_enable;
    wire logic       irq_next            = rise_irq_next | fall_irq_next;

    // Two-stage synchroniser for the analogue result
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= cmp_raw_i;
            sync2_reg <= sync1_reg;
        end
    end

    // Previous output state for edge detection
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= cmp_output_state;
        end
    end

    // Control register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmp_control_reg <= `CMPC_CTRL_RESET;
        end else begin
            cmp_control_reg <= ctrl_next;
        end
    end

    // Mode register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmp_response_mode_reg <= `CMPC_MODE_RESET;
        end else if (mode_wr) begin
            cmp_response_mode_reg <= sfr_wdata_i & `CMPC_MODE_MASK;
        end
    end

    // Registered read data
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sfr_rdata_reg <= 8'h00;
        end else begin
            sfr_rdata_reg <= rdata_next;
        end
    end

    // Synchronous pin output
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_sync_reg <= 1'b0;
        end else begin
            pin_sync_reg <= pin_sync_next;
        end
    end

    // Rise interrupt request
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rise_irq_reg <= 1'b0;
        end else begin
            rise_irq_reg <= rise_irq_next;
        end
    end

    // Fall interrupt request
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fall_irq_reg <= 1'b0;
        end else begin
            fall_irq_reg <= fall_irq_next;
        end
    end

    // Combined interrupt request
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    // Outputs
    assign sfr_rdata_o          = sfr_rdata_reg;
    assign cmp_pin_sync_o       = pin_sync_reg;
    // Clockless path: enable gates the raw result, works with clock stopped
    assign cmp_pin_async_o      = cmp_enable & route_async_i & cmp_raw_i;
    assign cmp_power_o          = cmp_enable;
    assign cmp_pos_hysteresis_o = cmpc_hyst_t'(cmp_pos_hyst_bits);
    assign cmp_neg_hysteresis_o = cmpc_hyst_t'(cmp_neg_hyst_bits);
    assign cmp_response_mode_o  = response_mode_bits;
    assign cmp_rise_irq_o       = rise_irq_reg;
    assign cmp_fall_irq_o       = fall_irq_reg;
    assign cmp_irq_o            = irq_reg;
endmodule // cmpc_top

// ---- cmpc_top_assertions.sv ----
// Purpose: Port assertions for the comparator control block
// Assumes: Control reads are judged only while the address is held
// Notes:   Bound to cmpc_top after the module
`timescale 1ns/100ps
module cmpc_checker (
    input wire logic                 clk_i,
    input wire logic                 rst_b_i,
    input wire logic [7:0]           sfr_addr_i,
    input wire logic                 sfr_wr_i,
    input wire logic [7:0]           sfr_wdata_i,
    input wire logic [7:0]           sfr_rdata_o,
    input wire logic                 cmp_raw_i,
    input wire logic                 route_async_i,
    input wire logic                 cmp_pin_async_o,
    input wire logic                 cmp_power_o,
    input wire cmpc_pkg::cmpc_hyst_t cmp_pos_hysteresis_o,
    input wire cmpc_pkg::cmpc_hyst_t cmp_neg_hysteresis_o,
    input wire cmpc_pkg::cmpc_mode_t cmp_response_mode_o,
    input wire logic                 cmp_rise_irq_o,
    input wire logic                 cmp_fall_irq_o,
    input wire logic                 cmp_irq_o
);
    import cmpc_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence ctrl_wr_s; sfr_wr_i && sfr_addr_i == 8'h9b; endsequence
    sequence held_s; sfr_addr_i == 8'h9b ##1 sfr_addr_i == 8'h9b && !sfr_wr_i; endsequence
    enable_follow_a: assert property (ctrl_wr_s |=> cmp_power_o == $past(sfr_wdata_i[7]))
        else $error("enable bit not applied");
    hyst_follow_a: assert property (ctrl_wr_s |=>
        {cmp_pos_hysteresis_o, cmp_neg_hysteresis_o} == $past(sfr_wdata_i[3:0])) else $error("bad hysteresis");
    mode_follow_a: assert property (sfr_wr_i && sfr_addr_i == 8'h9d |=>
        cmp_response_mode_o == $past(sfr_wdata_i[1:0])) else $error("bad response mode");
    async_pin_a: assert property (cmp_pin_async_o == (cmp_power_o && route_async_i && cmp_raw_i))
        else $error("async pin wrong");
    irq_merge_a: assert property (cmp_irq_o == (cmp_rise_irq_o || cmp_fall_irq_o))
        else $error("irq not merged");
    rise_flag_a: assert property (held_s ##1 $rose(sfr_rdata_o[6]) |-> sfr_rdata_o[5])
        else $error("rise flag missed");
    fall_flag_a: assert property (held_s ##1 $fell(sfr_rdata_o[6]) |-> sfr_rdata_o[4])
        else $error("fall flag missed");
    flag_hold_a: assert property (held_s ##1 1'b1 |->
        (sfr_rdata_o[5:4] & $past(sfr_rdata_o[5:4])) == $past(sfr_rdata_o[5:4])) else $error("flag lost");
endmodule // cmpc_checker
bind cmpc_top cmpc_checker u_chk (.*);

// ---- cmpc_top_test.sv ----
// Purpose: Self-checking bench for cmpc_top
// Assumes: Read data is compared two edges after the address is set
// Notes:   Driver queues expectations, monitor compares
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module cmpc_top_test;
    import cmpc_pkg::*;
    logic clk_i = 0, rst_b_i = 0, sfr_wr_i = 0, cmp_raw_i = 0, route_async_i = 0, look = 0;
    logic [7:0] sfr_addr_i = 0, sfr_wdata_i = 0, sfr_rdata_o, ctrl_m = 0, mode_m = 8'h02;
    logic cmp_pin_sync_o, cmp_pin_async_o, cmp_power_o, cmp_rise_irq_o, cmp_fall_irq_o, cmp_irq_o;
    cmpc_hyst_t cmp_pos_hysteresis_o, cmp_neg_hysteresis_o;
    cmpc_mode_t cmp_response_mode_o;
    logic [19:0] exp_v, got_v, q[$];
    int failures = 0, num_checks = 0, cycles = 0, i;
    cmpc_top dut (.*);
    always #2 clk_i = ~clk_i;
    function automatic logic [19:0] expv(logic [7:0] a);
        logic en, r, f;
        en = ctrl_m[7];
        r = ctrl_m[5] & mode_m[5];
        f = ctrl_m[4] & mode_m[4];
        return {ctrl_m[3:0], mode_m[1:0], en & ~route_async_i & cmp_raw_i,
            en & route_async_i & cmp_raw_i, r, f, r | f, en,
            a == 8'h9b ? ctrl_m | {1'b0, en & cmp_raw_i, 6'h0} : a == 8'h9d ? mode_m : 8'h00};
    endfunction
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk_i) {sfr_addr_i, sfr_wdata_i, sfr_wr_i} <= {a, d, 1'b1};
        @(posedge clk_i) sfr_wr_i <= 1'b0;
        if (a == 8'h9b) ctrl_m = {d[7], 1'b0, ctrl_m[5:4] & d[5:4], d[3:0]};
        if (a == 8'h9d) mode_m = d & 8'h33;
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge clk_i) sfr_addr_i <= a;
        @(posedge clk_i) look <= 1'b1;
        q.push_back(expv(a));
        @(posedge clk_i) look <= 1'b0;
    endtask
    task automatic raw(logic v);
        @(posedge clk_i) {cmp_raw_i, sfr_addr_i} <= {v, 8'h9b};
        if (ctrl_m[7] && v != cmp_raw_i) ctrl_m[4 + v] = 1'b1;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic test_done;
        if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 1000) begin failures++; test_done; end
        if (look) begin
            exp_v = q.pop_front();
            got_v = {cmp_pos_hysteresis_o, cmp_neg_hysteresis_o, cmp_response_mode_o, cmp_pin_sync_o,
                cmp_pin_async_o, cmp_rise_irq_o, cmp_fall_irq_o, cmp_irq_o, cmp_power_o, sfr_rdata_o};
            `CHK(got_v, exp_v)
        end
    end
    initial begin
        void'($urandom(32'hdf97a448));
        repeat (16) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(8'h9b);
        rd(8'h9d);
        rd(8'h9c);
        for (i = 0; i < 4; i++) begin
            route_async_i <= 1'($urandom);
            wr(8'h9b, {4'hf, i[1:0], ~i[1:0]});
            wr(8'h9d, {2'h0, i[1:0], 2'h0, 2'($urandom)});
            raw(1'b1);
            rd(8'h9b);
            raw(1'b0);
            rd(8'h9b);
            rd(8'h9d);
            wr(8'h9b, {4'h8, i[1:0], ~i[1:0]});
            rd(8'h9b);
            wr(8'h9b, 8'h00);
            rd(8'h9b);
            raw(1'b1);
            rd(8'h9b);
            raw(1'b0);
        end
        test_done;
    end
endmodule // cmpc_top_test
